// ---- drlc_host.sv ----
// module: axi4-lite controlled host that drives the converter's parallel and control pins
`timescale 1ns/1ps
// What this block does
// - Host counts the wake time after leaving power-down and flags it in the status settle bit.
// - Host writes by presenting word, direction low, then pulsing chip select low-high.
// - Host gives rising load strobe edge to copy input register to converter register.
// - Chip select comes from the pin sequencer and is low only in its S_LOW state.
module drlc_host (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic [15:0] data_i,
    output logic [15:0] data_o,
    output logic data_oe_n_o,
    output logic chip_select_n_o,
    output logic read_not_write_o,
    output logic output_load_strobe_o,
    output logic reset_strobe_o,
    output logic reset_level_select_o,
    output logic powerdown_select_high_o,
    output logic powerdown_select_low_o,
    output logic code_format_select_o
);
    import drlc_pkg::*;

    // ------------------------------------------------------------
    // reset release and pin input synchroniser
    // ------------------------------------------------------------
    logic [1:0] rst_sync_r;
    logic rst_n;
    logic [15:0] din_meta_r, din_sync_r;

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_sync_r <= 2'h0;
            din_meta_r <= 16'h0000;
            din_sync_r <= 16'h0000;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
            din_meta_r <= data_i;
            din_sync_r <= din_meta_r;
        end
    end
    assign rst_n = rst_sync_r[1];

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum logic [2:0] {H_IDLE, H_BUS, H_STROBE_LO, H_STROBE_HI} drlc_host_state_type;
    typedef struct packed {
        drlc_host_state_type st;
        logic [4:0] ctrl;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [CNT_W-1:0] cnt;
        logic [CNT_W-1:0] wake;
        logic pd_prev;
        logic cmd_load;
        logic bus_rd;
        logic ld_pin;
        logic rst_pin;
        logic aw_got;
        logic w_got;
        logic [7:0] awaddr;
        logic [31:0] wword;
        logic bvalid;
        logic rvalid;
        logic [31:0] rword;
        logic start;
    } drlc_host_type;
    drlc_host_type h_r, h_nxt;

    drlc_strobe_if sreq ();

    drlc_pin_seq u_seq (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .req(sreq.seq),
        .bus_in_i(din_sync_r),
        .cs_n_o(chip_select_n_o),
        .rw_o(read_not_write_o),
        .bus_oe_n_o(data_oe_n_o)
    );
    logic busy;
    logic [31:0] status;
    assign busy = (h_r.st != H_IDLE) || sreq.busy || h_r.start;
    assign status = {29'h0, (h_r.ctrl[CTRL_PD_LSB +: 2] != PD_NORMAL), (h_r.wake != '0), busy};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] wa;
        logic [31:0] wd;
        logic do_write;
        logic [CNT_W-1:0] wake_cyc;
        wa = 8'h00;
        wd = 32'h0;
        do_write = 1'b0;
        wake_cyc = '0;
        h_nxt = h_r;
        h_nxt.start = 1'b0;
        // axi write address and data captured independently
        if (s_axi_awvalid_i && !h_r.aw_got) begin
            h_nxt.aw_got = 1'b1;
            h_nxt.awaddr = s_axi_awaddr_i;
        end
        if (s_axi_wvalid_i && !h_r.w_got) begin
            h_nxt.w_got = 1'b1;
            h_nxt.wword = s_axi_wdata_i & {{8{s_axi_wstrb_i[3]}}, {8{s_axi_wstrb_i[2]}},
                {8{s_axi_wstrb_i[1]}}, {8{s_axi_wstrb_i[0]}}};
        end
        if (h_r.aw_got && h_r.w_got && !h_r.bvalid) begin
            do_write = 1'b1;
            wa = h_r.awaddr;
            wd = h_r.wword;
            h_nxt.aw_got = 1'b0;
            h_nxt.w_got = 1'b0;
            h_nxt.bvalid = 1'b1;
        end
        if (h_r.bvalid && s_axi_bready_i) begin
            h_nxt.bvalid = 1'b0;
        end
        // power-down exit wait: 5 V figure when the fast bit is set, else 3 V figure
        wake_cyc = h_r.ctrl[CTRL_FAST_BIT] ? CNT_W'(WAKE_5V_CYC) : CNT_W'(WAKE_3V_CYC);
        if (h_r.wake != '0) begin
            h_nxt.wake = h_r.wake - CNT_W'(1);
        end
        if (do_write) begin
            case (wa)
                OFF_CTRL: h_nxt.ctrl = wd[4:0];
                OFF_WDATA: h_nxt.wdata = wd[15:0];
                OFF_CMD: begin
                    if (!busy) begin
                        if (wd[CMD_WRITE_BIT] || wd[CMD_READ_BIT]) begin
                            h_nxt.start = 1'b1;
                            h_nxt.bus_rd = wd[CMD_READ_BIT] && !wd[CMD_WRITE_BIT];
                            h_nxt.cmd_load = wd[CMD_LOAD_BIT] && !h_nxt.bus_rd;
                            h_nxt.st = H_BUS;
                        end else if (wd[CMD_LOAD_BIT]) begin
                            h_nxt.ld_pin = 1'b0;
                            h_nxt.st = H_STROBE_LO;
                            h_nxt.cnt = CNT_W'(STROBE_CYC);
                        end else if (wd[CMD_RESET_BIT]) begin
                            h_nxt.rst_pin = 1'b0;
                            h_nxt.st = H_STROBE_LO;
                            h_nxt.cnt = CNT_W'(STROBE_CYC);
                        end
                    end
                end
                default: ;
            endcase
        end
        // leaving power-down starts the recovery wait
        h_nxt.pd_prev = (h_nxt.ctrl[CTRL_PD_LSB +: 2] != PD_NORMAL);
        if (h_r.pd_prev && !h_nxt.pd_prev) begin
            h_nxt.wake = wake_cyc;
        end
        case (h_r.st)
            H_IDLE: ;
            H_BUS: begin
                if (sreq.rdata_valid) begin
                    h_nxt.rdata = sreq.rdata;
                end
                if (!h_r.start && !sreq.busy) begin
                    if (h_r.cmd_load) begin
                        h_nxt.ld_pin = 1'b0;
                        h_nxt.st = H_STROBE_LO;
                        h_nxt.cnt = CNT_W'(STROBE_CYC);
                        h_nxt.cmd_load = 1'b0;
                    end else begin
                        h_nxt.st = H_IDLE;
                    end
                end
            end
            H_STROBE_LO: begin
                // strobes held low long enough for the device to see the edge
                if (h_r.cnt <= CNT_W'(1)) begin
                    h_nxt.ld_pin = 1'b1;
                    h_nxt.rst_pin = 1'b1;
                    h_nxt.st = H_STROBE_HI;
                    h_nxt.cnt = CNT_W'(STROBE_CYC);
                end else begin
                    h_nxt.cnt = h_r.cnt - CNT_W'(1);
                end
            end
            H_STROBE_HI: begin
                if (h_r.cnt <= CNT_W'(1)) begin
                    h_nxt.st = H_IDLE;
                end else begin
                    h_nxt.cnt = h_r.cnt - CNT_W'(1);
                end
            end
            default: h_nxt.st = H_IDLE;
        endcase
        // axi read
        if (s_axi_arvalid_i && !h_r.rvalid) begin
            h_nxt.rvalid = 1'b1;
            case (s_axi_araddr_i)
                OFF_CTRL: h_nxt.rword = {27'h0, h_r.ctrl};
                OFF_WDATA: h_nxt.rword = {16'h0, h_r.wdata};
                OFF_CMD: h_nxt.rword = 32'h0;
                OFF_STATUS: h_nxt.rword = status;
                OFF_RDATA: h_nxt.rword = {16'h0, h_r.rdata};
                default: h_nxt.rword = 32'h0;
            endcase
        end else if (h_r.rvalid && s_axi_rready_i) begin
            h_nxt.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            h_r <= '0;
            h_r.ctrl <= CTRL_RESET;
            h_r.ld_pin <= 1'b1;
            h_r.rst_pin <= 1'b1;
        end else begin
            h_r <= h_nxt;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign sreq.start = h_r.start;
    assign sreq.rd = h_r.bus_rd;
    assign s_axi_awready_o = !h_r.aw_got;
    assign s_axi_wready_o = !h_r.w_got;
    assign s_axi_bresp_o = 2'h0;
    assign s_axi_bvalid_o = h_r.bvalid;
    assign s_axi_arready_o = !h_r.rvalid;
    assign s_axi_rdata_o = h_r.rword;
    assign s_axi_rresp_o = 2'h0;
    assign s_axi_rvalid_o = h_r.rvalid;
    assign data_o = h_r.wdata;
    assign output_load_strobe_o = h_r.ld_pin;
    assign reset_strobe_o = h_r.rst_pin;
    assign reset_level_select_o = h_r.ctrl[CTRL_RESET_LEVEL_SELECT_BIT];
    assign powerdown_select_high_o = h_r.ctrl[CTRL_PD_LSB + 1];
    assign powerdown_select_low_o = h_r.ctrl[CTRL_PD_LSB];
    assign code_format_select_o = h_r.ctrl[CTRL_FMT_BIT];
endmodule

// ---- drlc_pkg.sv ----
// package: register map, pin encodings and timing counts of the converter host controller
package drlc_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned DATA_W = 16;
    // axi register offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_WDATA = 8'h04;
    localparam logic [7:0] OFF_CMD = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_RDATA = 8'h10;
    // control register fields
    localparam int unsigned CTRL_PD_LSB = 0;
    localparam int unsigned CTRL_RESET_LEVEL_SELECT_BIT = 2;
    localparam int unsigned CTRL_FMT_BIT = 3;
    localparam int unsigned CTRL_FAST_BIT = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    // command register bits
    localparam int unsigned CMD_WRITE_BIT = 0;
    localparam int unsigned CMD_LOAD_BIT = 1;
    localparam int unsigned CMD_RESET_BIT = 2;
    localparam int unsigned CMD_READ_BIT = 3;
    // status register bits
    localparam int unsigned ST_BUSY_BIT = 0;
    localparam int unsigned ST_SETTLE_BIT = 1;
    localparam int unsigned ST_PD_BIT = 2;
    // powerdown select codes
    localparam logic [1:0] PD_NORMAL = 2'h0;
    localparam logic [1:0] PD_1K = 2'h1;
    localparam logic [1:0] PD_100K = 2'h2;
    localparam logic [1:0] PD_HIZ = 2'h3;
    // min and mid scale codes per format, max scale code for two's complement only
    localparam logic [15:0] CODE_MIN_USB = 16'h0000;
    localparam logic [15:0] CODE_MIN_BTC = 16'h8000;
    localparam logic [15:0] CODE_MID_USB = 16'h8000;
    localparam logic [15:0] CODE_MID_BTC = 16'h0000;
    localparam logic [15:0] CODE_MAX_BTC = 16'h7FFF;
    // timing
    localparam int unsigned STROBE_NS = 80;
    localparam int unsigned STROBE_CYC = (STROBE_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned WAKE_5V_NS = 2500;
    localparam int unsigned WAKE_3V_NS = 5000;
    localparam int unsigned WAKE_5V_CYC = (WAKE_5V_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned WAKE_3V_CYC = (WAKE_3V_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned CNT_W = 8;
endpackage

// ---- drlc_strobe_if.sv ----
// interface: request and answer between the controller and its pin sequencer
`timescale 1ns/1ps
interface drlc_strobe_if;
    logic start;
    logic rd;
    logic busy;
    logic [15:0] rdata;
    logic rdata_valid;
    modport ctl (output start, output rd, input busy, input rdata, input rdata_valid);
    modport seq (input start, input rd, output busy, output rdata, output rdata_valid);
endinterface

// ---- drlc_pin_seq.sv ----
// module: parallel bus cycle sequencer driving chip select and direction pins
`timescale 1ns/1ps
module drlc_pin_seq (
    input wire logic clk_i,
    input wire logic rst_n_i,
    drlc_strobe_if.seq req,
    input wire logic [15:0] bus_in_i,
    output logic cs_n_o,
    output logic rw_o,
    output logic bus_oe_n_o
);
    import drlc_pkg::*;
    typedef enum logic [1:0] {S_IDLE, S_SETUP, S_LOW, S_HIGH} drlc_seq_state_type;
    typedef struct packed {
        drlc_seq_state_type st;
        logic [CNT_W-1:0] cnt;
        logic rd;
        logic [15:0] rdata;
        logic rvalid;
    } drlc_seq_type;
    drlc_seq_type s_r, s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.rvalid = 1'b0;
        case (s_r.st)
            S_IDLE: begin
                if (req.start) begin
                    s_nxt.st = S_SETUP;
                    s_nxt.rd = req.rd;
                    s_nxt.cnt = CNT_W'(STROBE_CYC);
                end
            end
            S_SETUP: begin
                // direction and data settle before the falling edge
                if (s_r.cnt <= CNT_W'(1)) begin
                    s_nxt.st = S_LOW;
                    s_nxt.cnt = CNT_W'(STROBE_CYC);
                end else begin
                    s_nxt.cnt = s_r.cnt - CNT_W'(1);
                end
            end
            S_LOW: begin
                if (s_r.cnt <= CNT_W'(1)) begin
                    s_nxt.st = S_HIGH;
                    s_nxt.cnt = CNT_W'(STROBE_CYC);
                end else begin
                    s_nxt.cnt = s_r.cnt - CNT_W'(1);
                end
            end
            S_HIGH: begin
                // the input synchroniser lags two edges, so the word driven while
                // chip select was low is seen on the first edge after it rises
                if (s_r.rd && (s_r.cnt == CNT_W'(STROBE_CYC))) begin
                    s_nxt.rdata = bus_in_i;
                    s_nxt.rvalid = 1'b1;
                end
                // hold after the rising edge of chip select
                if (s_r.cnt <= CNT_W'(1)) begin
                    s_nxt.st = S_IDLE;
                end else begin
                    s_nxt.cnt = s_r.cnt - CNT_W'(1);
                end
            end
            default: s_nxt.st = S_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign req.busy = (s_r.st != S_IDLE);
    assign req.rdata = s_r.rdata;
    assign req.rdata_valid = s_r.rvalid;
    assign cs_n_o = (s_r.st != S_LOW);
    assign rw_o = (s_r.st == S_IDLE) ? 1'b1 : s_r.rd;
    assign bus_oe_n_o = !((s_r.st != S_IDLE) && !s_r.rd);
endmodule

// ---- drlc_dev_model.sv ----
// model of the converter device seen by the host controller
`timescale 1ns/1ps
module drlc_dev_model (
    input wire logic [15:0] bus_i,
    input wire logic cs_n_i,
    input wire logic rw_i,
    input wire logic load_i,
    input wire logic rst_i,
    input wire logic rsel_i,
    input wire logic pd_hi_i,
    input wire logic pd_lo_i,
    input wire logic fmt_i,
    output logic [15:0] data_o
);
    // power-up leaves the converter at min-scale
    logic [15:0] in_r = 16'h0000;
    logic [15:0] conv_r = 16'h0000;
    logic [15:0] last_r = 16'h0000;
    logic load_prev = 1'b1;
    logic rst_prev = 1'b1;
    logic amp_on;
    assign amp_on = ({pd_hi_i, pd_lo_i} == 2'h0);
    always @(posedge cs_n_i) begin
        if (!rw_i) begin
            in_r <= bus_i;
        end else begin
            last_r <= in_r;
        end
    end
    // only a clean low-to-high change counts, never a pin settling out of unknown
    always @(load_i or rst_i) begin
        if (load_prev === 1'b0 && load_i === 1'b1) begin
            conv_r <= in_r;
        end
        if (rst_prev === 1'b0 && rst_i === 1'b1) begin
            conv_r <= (rsel_i ^ fmt_i) ? 16'h8000 : 16'h0000;
        end
        load_prev = load_i;
        rst_prev = rst_i;
    end
    // released bus shows the inverse of the last word
    assign data_o = (!cs_n_i && rw_i) ? in_r : ~last_r;
endmodule

// ---- drlc_host_properties.sv ----
// checker: pin and bus timing assertions of the converter host
`timescale 1ns/1ps
module drlc_host_checker (
    input wire logic clk_i,
    input wire logic nrst_i,
    input wire logic s_axi_arvalid_i,
    input wire logic s_axi_arready_o,
    input wire logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic data_oe_n_o,
    input wire logic chip_select_n_o,
    input wire logic read_not_write_o,
    input wire logic output_load_strobe_o,
    input wire logic reset_strobe_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    wr_drive_a: assert property (!data_oe_n_o |-> !read_not_write_o) else $error("bus driven in read");
    wr_cs_a: assert property (!chip_select_n_o && !read_not_write_o |-> !data_oe_n_o) else $error("write undriven");
    rd_release_a: assert property (read_not_write_o |-> data_oe_n_o) else $error("bus driven in read");
    cs_width_a: assert property ($fell(chip_select_n_o) |=> !chip_select_n_o ##1 chip_select_n_o) else $error("cs width");
    rw_hold_a: assert property (!chip_select_n_o |=> $stable(read_not_write_o) || chip_select_n_o) else $error("rw moved");
    load_pulse_a: assert property ($fell(output_load_strobe_o) |=> !output_load_strobe_o ##1 output_load_strobe_o)
        else $error("load pulse");
    rst_pulse_a: assert property ($fell(reset_strobe_o) |=> !reset_strobe_o ##1 reset_strobe_o)
        else $error("reset pulse");
    rd_answer_a: assert property (s_axi_arvalid_i && s_axi_arready_o && !s_axi_rvalid_o |=> s_axi_rvalid_o)
        else $error("late read answer");
    r_stand_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o) else $error("rvalid dropped");
    b_stand_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o) else $error("bvalid dropped");
    cover property ($rose(output_load_strobe_o));
    cover property ($rose(reset_strobe_o));
    cover property ($fell(chip_select_n_o) && read_not_write_o);
endmodule
bind drlc_host drlc_host_checker chk_i (.clk_i(clk_i), .nrst_i(nrst_i), .s_axi_arvalid_i(s_axi_arvalid_i),
    .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o), .s_axi_rready_i(s_axi_rready_i),
    .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i), .data_oe_n_o(data_oe_n_o),
    .chip_select_n_o(chip_select_n_o), .read_not_write_o(read_not_write_o),
    .output_load_strobe_o(output_load_strobe_o), .reset_strobe_o(reset_strobe_o));

// ---- testbench.sv ----
// testbench: axi-driven scenarios of the converter host against a device model
`timescale 1ns/1ps
module testbench;
    import drlc_pkg::*;
    logic clk_i = 1'b0, nrst_i = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000, rdata;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, oe_n, cs_n, rw, ld, rs, rsel, pdh, pdl, fmt;
    logic [1:0] bresp, rresp;
    logic [15:0] hdata, ddata;
    int n_mismatch = 0;
    int checks_done = 0;
    drlc_host uut (.clk_i(clk_i), .nrst_i(nrst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .data_i(ddata), .data_o(hdata),
        .data_oe_n_o(oe_n), .chip_select_n_o(cs_n), .read_not_write_o(rw), .output_load_strobe_o(ld),
        .reset_strobe_o(rs), .reset_level_select_o(rsel), .powerdown_select_high_o(pdh),
        .powerdown_select_low_o(pdl), .code_format_select_o(fmt));
    drlc_dev_model dev (.bus_i(hdata), .cs_n_i(cs_n), .rw_i(rw), .load_i(ld), .rst_i(rs), .rsel_i(rsel),
        .pd_hi_i(pdh), .pd_lo_i(pdl), .fmt_i(fmt), .data_o(ddata));
    initial forever #20 clk_i = ~clk_i;
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task lost;
        n_mismatch++;
        $display("unexpected at %0t: no answer", $time);
        give_verdict();
    endtask
    task axw(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic ah, wh, bh;
        logic [1:0] br;
        @(posedge clk_i);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        bh = 1'b0; n = 0; br = 2'h3;
        while (!bh && n < 100) begin
            @(negedge clk_i);
            ah = awvalid && awready; wh = wvalid && wready; bh = bvalid && bready; br = bresp;
            @(posedge clk_i);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
            n++;
        end
        bready <= 1'b0;
        if (bh) begin
            chk(32'(br), 32'h0);
        end else begin
            lost();
        end
    endtask
    task axr(input logic [7:0] a, output logic [31:0] d);
        int n;
        logic ah, rh;
        logic [1:0] rr;
        @(posedge clk_i);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        rh = 1'b0; n = 0; rr = 2'h3;
        while (!rh && n < 100) begin
            @(negedge clk_i);
            ah = arvalid && arready; rh = rvalid && rready; d = rdata; rr = rresp;
            @(posedge clk_i);
            if (ah) arvalid <= 1'b0;
            n++;
        end
        rready <= 1'b0;
        if (rh) begin
            chk(32'(rr), 32'h0);
        end else begin
            lost();
        end
    endtask
    // poll a status bit until it clears
    task wait_clear(input int b);
        logic [31:0] s;
        int n;
        n = 0;
        s = 32'h0000_0001 << b;
        while (s[b] !== 1'b0 && n < 100) begin
            axr(OFF_STATUS, s);
            n++;
        end
        if (s[b] !== 1'b0) lost();
    endtask
    task cmd(input int b);
        axw(OFF_CMD, 32'h1 << b);
        wait_clear(ST_BUSY_BIT);
    endtask
    task put(input logic [15:0] w);
        axw(OFF_WDATA, 32'(w));
        cmd(CMD_WRITE_BIT);
        chk(32'(dev.in_r), 32'(w));
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task sc_after_reset;
        logic [31:0] d;
        axr(OFF_CTRL, d);
        chk(d, 32'(CTRL_RESET));
        axr(8'h14, d);
        chk(d, 32'h0000_0000);
        chk(32'(oe_n), 32'h1);
        put(16'hA5C3);
        chk(32'(dev.conv_r), 32'h0000_0000);
        cmd(CMD_LOAD_BIT);
        chk(32'(dev.conv_r), 32'h0000_A5C3);
        chk(32'(dev.in_r), 32'h0000_A5C3);
        cmd(CMD_READ_BIT);
        axr(OFF_RDATA, d);
        chk(d, 32'h0000_A5C3);
    endtask
    task sc_reset_edge;
        axw(OFF_CTRL, 32'h1 << CTRL_RESET_LEVEL_SELECT_BIT);
        chk(32'(rsel), 32'h1);
        cmd(CMD_RESET_BIT);
        chk(32'(dev.conv_r), 32'h0000_8000);
        axw(OFF_CTRL, 32'h0000_0000);
        chk(32'(dev.conv_r), 32'h0000_8000);
        cmd(CMD_RESET_BIT);
        chk(32'(dev.conv_r), 32'h0000_0000);
        chk(32'(dev.in_r), 32'h0000_A5C3);
    endtask
    task sc_powerdown;
        logic [31:0] d;
        cmd(CMD_LOAD_BIT);
        for (int c = 1; c < 4; c++) begin
            axw(OFF_CTRL, 32'(c));
            chk(32'({pdh, pdl}), 32'(c));
            chk(32'(dev.amp_on), 32'h0);
            axr(OFF_STATUS, d);
            chk(32'(d[ST_PD_BIT]), 32'h1);
        end
        // first pass leaves with the slow wake figure, second with the fast one
        for (int f = 0; f < 2; f++) begin
            if (f == 1) begin
                axw(OFF_CTRL, (32'h1 << CTRL_FAST_BIT) | 32'(PD_HIZ));
            end
            axw(OFF_CTRL, 32'(f) << CTRL_FAST_BIT);
            chk(32'(dev.amp_on), 32'h1);
            repeat (((f == 1) ? WAKE_5V_CYC : WAKE_3V_CYC) - 8) @(posedge clk_i);
            axr(OFF_STATUS, d);
            chk(32'(d[ST_SETTLE_BIT]), 32'h1);
            repeat (16) @(posedge clk_i);
            axr(OFF_STATUS, d);
            chk(32'(d[ST_SETTLE_BIT]), 32'h0);
        end
        chk(32'(dev.conv_r), 32'h0000_A5C3);
    endtask
    task sc_twos;
        logic [31:0] d;
        axw(OFF_CTRL, 32'h1 << CTRL_FMT_BIT);
        chk(32'(fmt), 32'h1);
        cmd(CMD_RESET_BIT);
        chk(32'(dev.conv_r), 32'(CODE_MIN_BTC));
        axw(OFF_CTRL, (32'h1 << CTRL_FMT_BIT) | (32'h1 << CTRL_RESET_LEVEL_SELECT_BIT));
        cmd(CMD_RESET_BIT);
        chk(32'(dev.conv_r), 32'(CODE_MID_BTC));
        axw(OFF_WDATA, 32'(CODE_MAX_BTC));
        axw(OFF_CMD, (32'h1 << CMD_WRITE_BIT) | (32'h1 << CMD_LOAD_BIT));
        wait_clear(ST_BUSY_BIT);
        chk(32'(dev.in_r), 32'(CODE_MAX_BTC));
        chk(32'(dev.conv_r), 32'(CODE_MAX_BTC));
        cmd(CMD_READ_BIT);
        axr(OFF_RDATA, d);
        chk(d, 32'(CODE_MAX_BTC));
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        nrst_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        sc_after_reset();
        sc_reset_edge();
        sc_powerdown();
        sc_twos();
        give_verdict();
    end
    initial begin
        #2000000;
        lost();
    end
endmodule
